// File: common/decode_pkg.sv
/*
 * Shared constants and types for the host cycle address decoder:
 * register indices, reset values, address ranges and route targets.
 * Assumes a 32-bit host address and a 16-bit I/O port space.
 */
`default_nettype none
package decode_pkg;

    // register port
    localparam int REG_AW = 4;
    localparam int REG_DW = 32;
    localparam logic [3:0] REG_FW_EN = 4'h0;
    localparam logic [3:0] REG_FW_EN_TWO = 4'h1;
    localparam logic [3:0] REG_CTRL = 4'h2;
    localparam logic [3:0] REG_TOM = 4'h3;
    localparam logic [3:0] REG_LAN_BASE = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_ROUTED = 4'h6;
    localparam logic [3:0] REG_DEFAULTED = 4'h7;

    // reset values
    localparam logic [7:0] FW_EN_RST = 8'hFF;
    localparam logic [7:0] FW_EN_TWO_RST = 8'h0F;
    localparam logic [31:0] TOM_RST = 32'h0010_0000;
    localparam logic [31:0] LAN_BASE_RST = 32'h0000_0000;

    // control bit positions
    localparam int CTRL_IDE_PRI = 0;
    localparam int CTRL_IDE_SEC = 1;
    localparam int CTRL_F0_DIS = 2;
    localparam int CTRL_LAN_EN = 3;
    localparam int CTRL_W = 4;

    // firmware window layout
    localparam int FW_LOW_WINDOWS = 7;
    localparam int FW_LEGACY_BIT = 7;
    localparam int FW_TWO_WINDOWS = 4;
    localparam logic [31:0] FW_HI_BASE = 32'hFFC0_0000;
    localparam logic [31:0] FW_LO_BASE = 32'hFF80_0000;
    localparam logic [31:0] FW_STEP = 32'h0008_0000;
    localparam logic [31:0] FW2_HI_BASE = 32'hFF40_0000;
    localparam logic [31:0] FW2_LO_BASE = 32'hFF00_0000;
    localparam logic [31:0] FW2_STEP = 32'h0010_0000;
    localparam logic [31:0] FW_TOP_LO = 32'hFFF8_0000;
    localparam logic [31:0] FW_MID_LO = 32'hFFB8_0000;
    localparam logic [31:0] FW_MID_HI = 32'hFFBF_FFFF;
    localparam logic [31:0] FW_LEG_LO = 32'h000E_0000;
    localparam logic [31:0] FW_LEG_HI = 32'h000F_FFFF;

    // memory ranges
    localparam logic [31:0] MEM_LOW_HI = 32'h000D_FFFF;
    localparam logic [31:0] MEM_HIGH_LO = 32'h0010_0000;
    localparam logic [31:0] APIC_LO = 32'hFEC0_0000;
    localparam logic [31:0] APIC_HI = 32'hFEC0_0100;

    // i/o ports
    localparam logic [15:0] IO_DMA_A_LO = 16'h0090;
    localparam logic [15:0] IO_DMA_A_HI = 16'h0091;
    localparam logic [15:0] IO_RST_A = 16'h0092;
    localparam logic [15:0] IO_DMA_B_LO = 16'h0093;
    localparam logic [15:0] IO_DMA_B_HI = 16'h009F;
    localparam logic [15:0] IO_PIC_LO = 16'h00A0;
    localparam logic [15:0] IO_PIC_HI = 16'h00BD;
    localparam int IO_PIC_GAP_BIT = 1;
    localparam logic [15:0] IO_PM_LO = 16'h00B2;
    localparam logic [15:0] IO_PM_HI = 16'h00B3;
    localparam logic [15:0] IO_DMA_C_LO = 16'h00C0;
    localparam logic [15:0] IO_DMA_C_HI = 16'h00D1;
    localparam logic [15:0] IO_DMA_W_LO = 16'h00D2;
    localparam logic [15:0] IO_DMA_W_HI = 16'h00DD;
    localparam logic [15:0] IO_DMA_D_LO = 16'h00DE;
    localparam logic [15:0] IO_DMA_D_HI = 16'h00DF;
    localparam logic [15:0] IO_F0 = 16'h00F0;
    localparam logic [15:0] IO_IDE_PRI_LO = 16'h0170;
    localparam logic [15:0] IO_IDE_PRI_HI = 16'h0177;
    localparam logic [15:0] IO_IDE_PRI_CTL = 16'h0376;
    localparam logic [15:0] IO_IDE_SEC_LO = 16'h01F0;
    localparam logic [15:0] IO_IDE_SEC_HI = 16'h01F7;
    localparam logic [15:0] IO_IDE_SEC_CTL = 16'h03F6;
    localparam logic [15:0] IO_ELCR_LO = 16'h04D0;
    localparam logic [15:0] IO_ELCR_HI = 16'h04D1;
    localparam logic [15:0] IO_RST_B = 16'h0CF9;

    typedef enum logic [3:0] {
        TGT_NONE = 4'h0,
        TGT_DMA = 4'h1,
        TGT_INTR = 4'h2,
        TGT_RESET = 4'h3,
        TGT_POWER = 4'h4,
        TGT_PROC_IF = 4'h5,
        TGT_IDE = 4'h6,
        TGT_LPC = 4'h7,
        TGT_PCI = 4'h8,
        TGT_MAIN_MEM = 4'h9,
        TGT_FIRMWARE_HUB = 4'hA,
        TGT_IO_INTERRUPT_ROUTER = 4'hB,
        TGT_LAN = 4'hC
    } target_t;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic is_write;
        logic [31:0] addr;
    } host_cycle_t;

    typedef struct packed {
        logic valid;
        logic claimed;
        target_t target;
    } route_t;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [REG_DW-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : decode_pkg
`default_nettype wire

// File: rtl/host_cycle_address_decoder.sv
/*
 * Host cycle address decoder: classifies each host I/O or memory
 * cycle and names the unit or bus that takes it, plus its
 * software-visible decode enables.
 * Assumes cycles and register strobes are synchronous to clock_in;
 * a cycle is presented for one clock and its route comes back one
 * clock later.
 */
`default_nettype none
module host_cycle_address_decoder
    import decode_pkg::*;
#(
    parameter int LAN_SIZE_LOG2 = 12,
    parameter int COUNT_W = 16
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // host cycles
    input wire host_cycle_t host_cycle_in,
    // route result
    output var route_t route_out,
    // register port
    input wire reg_req_t reg_req_in,
    output logic [REG_DW-1:0] reg_rdata_out
);

    if (LAN_SIZE_LOG2 < 4 || LAN_SIZE_LOG2 > 31) begin : g_bad_lan
        $error("LAN_SIZE_LOG2 must lie in 4..31");
    end
    if (COUNT_W < 1 || COUNT_W > REG_DW) begin : g_bad_count
        $error("COUNT_W must lie in 1..32");
    end

    localparam logic [31:0] LAN_MASK =
        ~((32'h0000_0001 << LAN_SIZE_LOG2) - 32'h0000_0001);

    typedef struct packed {
        logic [7:0] fw_en;
        logic [7:0] fw_en_two;
        logic [CTRL_W-1:0] ctrl;
        logic [31:0] top_of_memory_limit;
        logic [31:0] lan_base;
        target_t last_target;
        logic [COUNT_W-1:0] routed;
        logic [COUNT_W-1:0] defaulted;
        route_t route;
        logic [REG_DW-1:0] rdata;
    } state_t;

    state_t state_q;
    state_t state_d;

    // firmware window hits, one per enable bit below the legacy bit
    logic [FW_LOW_WINDOWS-1:0] fw_hit;
    logic [FW_TWO_WINDOWS-1:0] fw_two_hit;
    logic [31:0] a;

    assign a = host_cycle_in.addr;

    for (genvar n = 0; n < FW_LOW_WINDOWS; n++) begin : g_fw
        localparam logic [31:0] HI_B = FW_HI_BASE + FW_STEP * n;
        localparam logic [31:0] LO_B = FW_LO_BASE + FW_STEP * n;
        assign fw_hit[n] = state_q.fw_en[n] &&
            ((a >= HI_B && a <= HI_B + FW_STEP - 32'h1) ||
             (a >= LO_B && a <= LO_B + FW_STEP - 32'h1));
    end

    for (genvar n = 0; n < FW_TWO_WINDOWS; n++) begin : g_fw_two
        localparam logic [31:0] HI_B = FW2_HI_BASE + FW2_STEP * n;
        localparam logic [31:0] LO_B = FW2_LO_BASE + FW2_STEP * n;
        assign fw_two_hit[n] = state_q.fw_en_two[n] &&
            ((a >= HI_B && a <= HI_B + FW2_STEP - 32'h1) ||
             (a >= LO_B && a <= LO_B + FW2_STEP - 32'h1));
    end

    function automatic logic in_io(input logic [15:0] p,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
        in_io = (p >= lo) && (p <= hi);
    endfunction : in_io

    // i/o decode; reserved reads fall through to the default bus
    function automatic target_t io_target(input logic [15:0] p,
                                          input logic wr,
                                          input logic [CTRL_W-1:0] c);
        target_t t;
        t = TGT_PCI;
        if (in_io(p, IO_DMA_A_LO, IO_DMA_A_HI)) begin
            t = TGT_DMA;
        end else if (p == IO_RST_A) begin
            t = TGT_RESET;
        end else if (in_io(p, IO_DMA_B_LO, IO_DMA_B_HI)) begin
            t = TGT_DMA;
        end else if (in_io(p, IO_PM_LO, IO_PM_HI)) begin
            t = TGT_POWER;
        end else if (in_io(p, IO_PIC_LO, IO_PIC_HI)) begin
            // pairs every four ports; the odd pairs are holes
            if (!p[IO_PIC_GAP_BIT]) begin
                t = TGT_INTR;
            end
        end else if (in_io(p, IO_DMA_C_LO, IO_DMA_C_HI)) begin
            t = TGT_DMA;
        end else if (in_io(p, IO_DMA_W_LO, IO_DMA_W_HI)) begin
            // write-only registers: reads are not ours
            if (wr) begin
                t = TGT_DMA;
            end
        end else if (in_io(p, IO_DMA_D_LO, IO_DMA_D_HI)) begin
            t = TGT_DMA;
        end else if (p == IO_F0) begin
            if (wr) begin
                t = TGT_PROC_IF;
            end else if (c[CTRL_F0_DIS]) begin
                t = TGT_NONE;
            end else begin
                t = TGT_LPC;
            end
        end else if (in_io(p, IO_IDE_PRI_LO, IO_IDE_PRI_HI) ||
                     p == IO_IDE_PRI_CTL) begin
            if (c[CTRL_IDE_PRI]) begin
                t = TGT_IDE;
            end
        end else if (in_io(p, IO_IDE_SEC_LO, IO_IDE_SEC_HI) ||
                     p == IO_IDE_SEC_CTL) begin
            if (c[CTRL_IDE_SEC]) begin
                t = TGT_IDE;
            end
        end else if (in_io(p, IO_ELCR_LO, IO_ELCR_HI)) begin
            t = TGT_INTR;
        end else if (p == IO_RST_B) begin
            t = TGT_RESET;
        end
        return t;
    endfunction : io_target

    // memory decode: fixed internal windows first, then firmware,
    // then the relocatable lan window, then dram and legacy firmware, else the default
    function automatic target_t mem_target(input logic [31:0] m,
                                           input state_t s,
                                           input logic fw_any);
        target_t t;
        t = TGT_PCI;
        if (m >= APIC_LO && m <= APIC_HI) begin
            t = TGT_IO_INTERRUPT_ROUTER;
        end else if (m >= FW_TOP_LO) begin
            t = TGT_FIRMWARE_HUB;
        end else if (m >= FW_MID_LO && m <= FW_MID_HI) begin
            t = TGT_FIRMWARE_HUB;
        end else if (fw_any) begin
            t = TGT_FIRMWARE_HUB;
        end else if (s.ctrl[CTRL_LAN_EN] &&
                     (m & LAN_MASK) == (s.lan_base & LAN_MASK)) begin
            t = TGT_LAN;
        end else if (m <= MEM_LOW_HI) begin
            t = TGT_MAIN_MEM;
        end else if (m >= FW_LEG_LO && m <= FW_LEG_HI) begin
            if (s.fw_en[FW_LEGACY_BIT]) begin
                t = TGT_FIRMWARE_HUB;
            end
        end else if (m >= MEM_HIGH_LO && m < s.top_of_memory_limit) begin
            t = TGT_MAIN_MEM;
        end
        return t;
    endfunction : mem_target

    target_t tgt;

    always_comb begin
        if (host_cycle_in.is_io) begin
            tgt = io_target(a[15:0], host_cycle_in.is_write,
                            state_q.ctrl);
        end else begin
            tgt = mem_target(a, state_q, |{fw_hit, fw_two_hit});
        end
    end

    always_comb begin
        state_d = state_q;
        state_d.route.valid = 1'b0;
        state_d.rdata = '0;

        // route result: one clock after the cycle
        if (host_cycle_in.valid) begin
            state_d.route.valid = 1'b1;
            state_d.route.target = tgt;
            state_d.route.claimed = (tgt != TGT_NONE);
            state_d.last_target = tgt;
            state_d.routed = state_q.routed + 1'b1;
            if (tgt == TGT_PCI) begin
                state_d.defaulted = state_q.defaulted + 1'b1;
            end
        end

        // register writes; counters clear on any write to them
        if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                REG_FW_EN: begin
                    state_d.fw_en = reg_req_in.wdata[7:0];
                end
                REG_FW_EN_TWO: begin
                    state_d.fw_en_two = {4'h0,
                        reg_req_in.wdata[FW_TWO_WINDOWS-1:0]};
                end
                REG_CTRL: begin
                    state_d.ctrl = reg_req_in.wdata[CTRL_W-1:0];
                end
                REG_TOM: begin
                    state_d.top_of_memory_limit = reg_req_in.wdata;
                end
                REG_LAN_BASE: begin
                    state_d.lan_base = reg_req_in.wdata & LAN_MASK;
                end
                REG_ROUTED: begin
                    state_d.routed = '0;
                end
                REG_DEFAULTED: begin
                    state_d.defaulted = '0;
                end
                default: begin
                end
            endcase
        end

        // register reads; unmapped indices read zero
        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                REG_FW_EN: begin
                    state_d.rdata = {24'h0, state_q.fw_en};
                end
                REG_FW_EN_TWO: begin
                    state_d.rdata = {24'h0, state_q.fw_en_two};
                end
                REG_CTRL: begin
                    state_d.rdata = {{(REG_DW-CTRL_W){1'b0}},
                                     state_q.ctrl};
                end
                REG_TOM: begin
                    state_d.rdata = state_q.top_of_memory_limit;
                end
                REG_LAN_BASE: begin
                    state_d.rdata = state_q.lan_base;
                end
                REG_STATUS: begin
                    state_d.rdata = {28'h0, state_q.last_target};
                end
                REG_ROUTED: begin
                    state_d.rdata = REG_DW'(state_q.routed);
                end
                REG_DEFAULTED: begin
                    state_d.rdata = REG_DW'(state_q.defaulted);
                end
                default: begin
                    state_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_q.fw_en <= FW_EN_RST;
            state_q.fw_en_two <= FW_EN_TWO_RST;
            state_q.ctrl <= '0;
            state_q.top_of_memory_limit <= TOM_RST;
            state_q.lan_base <= LAN_BASE_RST;
            state_q.last_target <= TGT_NONE;
            state_q.routed <= '0;
            state_q.defaulted <= '0;
            state_q.route <= '0;
            state_q.rdata <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign route_out = state_q.route;
    assign reg_rdata_out = state_q.rdata;

endmodule : host_cycle_address_decoder
`default_nettype wire

// File: tb/host_cycle_partner.sv
/*
 * Host processor model: issues one I/O or memory cycle at a time.
 * Assumes the bench calls issue and samples the route itself.
 */
`default_nettype none
module host_cycle_partner
    import decode_pkg::*;
(
    // clock
    input wire logic clock_in,
    // host cycles
    output var host_cycle_t host_cycle_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial host_cycle_out = '0;
    task automatic issue(input logic io, input logic wr,
                         input logic [31:0] a);
        @(posedge clock_in);
        host_cycle_out <= '{1'b1, io, wr, a};
        @(posedge clock_in);
        // idle fields are inverted so a stale cycle never looks valid
        host_cycle_out <= '{1'b0, ~io, ~wr, ~a};
    endtask : issue
endmodule : host_cycle_partner
`default_nettype wire

// File: tb/host_cycle_address_decoder_properties.sv
/*
 * Port-level checks of the host cycle decoder's fixed routes.
 * Assumes only the top module's ports; register state is not seen.
 */
`default_nettype none
module host_cycle_address_decoder_properties
    import decode_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // host side
    input wire host_cycle_t host_cycle_in,
    input wire route_t route_out,
    // register port
    input wire reg_req_t reg_req_in,
    input wire logic [REG_DW-1:0] reg_rdata_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    logic io_v;
    logic mem_v;
    logic [15:0] p;
    logic [31:0] a;
    assign io_v = host_cycle_in.valid && host_cycle_in.is_io;
    assign mem_v = host_cycle_in.valid && !host_cycle_in.is_io;
    assign p = host_cycle_in.addr[15:0];
    assign a = host_cycle_in.addr;
    route_timing_a: assert property (
        host_cycle_in.valid |=> route_out.valid)
        else $error("route did not follow a cycle");
    route_cause_a: assert property (
        route_out.valid |-> $past(host_cycle_in.valid))
        else $error("route without a cycle");
    claim_flag_a: assert property (
        route_out.valid
        |-> route_out.claimed == (route_out.target != TGT_NONE))
        else $error("claimed flag disagrees with target");
    reset_port_a: assert property (
        io_v && (p == IO_RST_A || p == IO_RST_B)
        |=> route_out.target == TGT_RESET)
        else $error("reset port misrouted");
    power_port_a: assert property (
        io_v && p inside {[IO_PM_LO:IO_PM_HI]}
        |=> route_out.target == TGT_POWER)
        else $error("power port misrouted");
    router_window_a: assert property (
        mem_v && a inside {[APIC_LO:APIC_HI]}
        |=> route_out.target == TGT_IO_INTERRUPT_ROUTER)
        else $error("router window misrouted");
    boot_top_a: assert property (
        mem_v && a >= FW_TOP_LO
        |=> route_out.target == TGT_FIRMWARE_HUB)
        else $error("top boot window misrouted");
    boot_mid_a: assert property (
        mem_v && a inside {[FW_MID_LO:FW_MID_HI]}
        |=> route_out.target == TGT_FIRMWARE_HUB)
        else $error("lower boot window misrouted");
    io_default_a: assert property (
        io_v && p[15:8] == 8'h02
        |=> route_out.target == TGT_PCI)
        else $error("unlisted port not sent to pci");
endmodule : host_cycle_address_decoder_properties
bind host_cycle_address_decoder host_cycle_address_decoder_properties chk (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .host_cycle_in(host_cycle_in),
    .route_out(route_out),
    .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out)
);
`default_nettype wire

// File: tb/host_cycle_address_decoder_tb.sv
/*
 * Self-checking bench: register reset values, i/o and memory routes.
 * Assumes the partner model drives host cycles, the bench the registers.
 */
`default_nettype none
module host_cycle_address_decoder_tb;
    import decode_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in;
    logic reset_in;
    host_cycle_t cyc;
    route_t route;
    reg_req_t req;
    logic [REG_DW-1:0] rdata;
    int fails;
    int cmp_count;
    int routed_n;
    int pci_n;
    logic [7:0] fw;
    logic [7:0] fw2;
    logic [3:0] ctrl;
    logic [31:0] top_of_memory_limit;
    logic [31:0] lan;
    logic [31:0] rv;
    logic [31:0] rst_tab [5] = '{32'(FW_EN_RST), 32'(FW_EN_TWO_RST), 32'h0,
                                 TOM_RST, LAN_BASE_RST};
    logic [15:0] ide_p [6] = '{16'h0170, 16'h0177, 16'h0376,
                               16'h01F0, 16'h01F7, 16'h03F6};
    logic [31:0] corner [10] = '{32'h000D_FFFF, 32'h000E_0000, 32'h0010_0000,
        32'hFEC0_0100, 32'hFEC0_0101, 32'hFFB7_FFFF, 32'hFF3F_FFFF,
        32'hFF40_0000, 32'hFFF8_0000, 32'hFFBF_FFFF};

    host_cycle_address_decoder DUT (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .host_cycle_in(cyc),
        .route_out(route),
        .reg_req_in(req),
        .reg_rdata_out(rdata)
    );
    host_cycle_partner host (
        .clock_in(clock_in),
        .host_cycle_out(cyc)
    );

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // subtraction wraps, so one unsigned compare bounds each window
    function automatic logic in_fw(input logic [31:0] a);
        logic h = 1'b0;
        for (int n = 0; n < FW_LOW_WINDOWS; n++) begin
            if (fw[n] && (a - (FW_HI_BASE + n * FW_STEP) < FW_STEP ||
                a - (FW_LO_BASE + n * FW_STEP) < FW_STEP)) h = 1'b1;
        end
        for (int n = 0; n < FW_TWO_WINDOWS; n++) begin
            if (fw2[n] && (a - (FW2_HI_BASE + n * FW2_STEP) < FW2_STEP ||
                a - (FW2_LO_BASE + n * FW2_STEP) < FW2_STEP)) h = 1'b1;
        end
        return h;
    endfunction : in_fw

    function automatic target_t exp_mem(input logic [31:0] a);
        if (a >= APIC_LO && a <= APIC_HI) return TGT_IO_INTERRUPT_ROUTER;
        if (a >= FW_TOP_LO || (a >= FW_MID_LO && a <= FW_MID_HI) || in_fw(a))
            return TGT_FIRMWARE_HUB;
        if (ctrl[CTRL_LAN_EN] && a[31:12] == lan[31:12]) return TGT_LAN;
        if (a <= MEM_LOW_HI) return TGT_MAIN_MEM;
        if (a >= FW_LEG_LO && a <= FW_LEG_HI && fw[FW_LEGACY_BIT])
            return TGT_FIRMWARE_HUB;
        if (a >= MEM_HIGH_LO && a < top_of_memory_limit) return TGT_MAIN_MEM;
        return TGT_PCI;
    endfunction : exp_mem

    task automatic check(input string name, input logic [31:0] got,
                         input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_in);
        req <= '{a, ~d, 1'b0, 1'b0};
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_in);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock_in);
        req.rd <= 1'b0;
        @(negedge clock_in);
        d = rdata;
    endtask : reg_rd

    task automatic setup(input logic [7:0] f, input logic [7:0] f2,
        input logic [3:0] c, input logic [31:0] tm, input logic [31:0] ln);
        fw = f;
        fw2 = f2 & 8'h0F;
        ctrl = c;
        top_of_memory_limit = tm;
        lan = ln;
        reg_wr(REG_FW_EN, 32'(f));
        reg_wr(REG_FW_EN_TWO, 32'(f2));
        reg_wr(REG_CTRL, 32'(c));
        reg_wr(REG_TOM, tm);
        reg_wr(REG_LAN_BASE, ln);
    endtask : setup

    task automatic route_chk(input logic io, input logic wr,
                             input logic [31:0] a, input target_t t);
        host.issue(io, wr, a);
        routed_n++;
        if (t == TGT_PCI) pci_n++;
        @(negedge clock_in);
        check("route", 32'({route.valid, route.claimed, route.target}),
              32'({1'b1, t != TGT_NONE, t}));
    endtask : route_chk

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        req = '0;
        reset_in = 1'b1;
        fails = 0;
        cmp_count = 0;
        routed_n = 0;
        pci_n = 0;
        fw = FW_EN_RST;
        fw2 = FW_EN_TWO_RST;
        ctrl = 4'h0;
        top_of_memory_limit = TOM_RST;
        lan = LAN_BASE_RST;
        rv = $urandom(32'h296D);
        repeat (10) @(posedge clock_in);
        reset_in <= 1'b0;
        foreach (rst_tab[i]) begin
            reg_rd(4'(i), rv);
            check("reset value", rv, rst_tab[i]);
        end
        reg_rd(4'hF, rv);
        check("unmapped", rv, 32'h0);
        foreach (corner[i]) begin
            route_chk(1'b0, 1'b0,
                corner[i], exp_mem(corner[i]));
        end
        reg_wr(REG_FW_EN_TWO, 32'hFFFF_FFFF);
        reg_rd(REG_FW_EN_TWO, rv);
        check("fw two width", rv, 32'h0000_000F);
        for (int c = 0; c < 8; c++) begin
            setup(FW_EN_RST, FW_EN_TWO_RST, 4'(c), TOM_RST, 32'h0);
            foreach (ide_p[i]) route_chk(1'b1, 1'($urandom),
                32'(ide_p[i]), ctrl[i / 3] ? TGT_IDE : TGT_PCI);
            route_chk(1'b1, 1'b0, 32'(IO_F0),
                ctrl[CTRL_F0_DIS] ? TGT_NONE : TGT_LPC);
            route_chk(1'b1, 1'b1, 32'(IO_F0), TGT_PROC_IF);
            route_chk(1'b1, c[0], 32'(IO_RST_A), TGT_RESET);
            route_chk(1'b1, c[0], 32'(IO_RST_B), TGT_RESET);
            route_chk(1'b1, c[0],
                32'(IO_PM_LO + 16'(c[1])), TGT_POWER);
            // reserved dma reads and interrupt holes fall to the default bus
            route_chk(1'b1, c[0], 32'h0000_00D2 + 32'(c),
                c[0] ? TGT_DMA : TGT_PCI);
            route_chk(1'b1, c[0], 32'h0000_00A0 + 32'(c),
                c[1] ? TGT_PCI : TGT_INTR);
            route_chk(1'b1, c[0], 32'h0000_0200 + 32'(c), TGT_PCI);
            reg_rd(REG_STATUS, rv);
            check("status", rv, 32'(TGT_PCI));
            reg_rd(REG_ROUTED, rv);
            check("routed", rv, 32'(16'(routed_n)));
            reg_rd(REG_DEFAULTED, rv);
            check("defaulted", rv, 32'(16'(pci_n)));
            reg_wr(REG_ROUTED, 32'h0);
            reg_wr(REG_DEFAULTED, 32'h0);
            routed_n = 0;
            pci_n = 0;
        end
        repeat (40) begin
            setup(8'($urandom), 8'($urandom), 4'($urandom),
                  MEM_HIGH_LO + ($urandom & 32'h0FFF_FFFF),
                  {4'hD, 16'($urandom), 12'h000});
            repeat (8) begin
                case ($urandom % 5)
                    0: rv = $urandom & 32'h001F_FFFF;
                    1: rv = 32'hFF00_0000 | ($urandom & 32'h00FF_FFFF);
                    2: rv = APIC_LO + 32'h0F0 + ($urandom % 32);
                    3: rv = lan - 32'h1000 + ($urandom & 32'h1FFF);
                    default: rv = top_of_memory_limit - 1 + ($urandom % 2);
                endcase
                route_chk(1'b0,
                    1'($urandom), rv, exp_mem(rv));
            end
        end
        finish_test();
    end

    // the full run takes under two thousand cycles
    initial begin
        repeat (20000) @(posedge clock_in);
        fails++;
        finish_test();
    end
endmodule : host_cycle_address_decoder_tb
`default_nettype wire
